// ### dbg_acc_consts.svh
`ifndef DBG_ACC_CONSTS_SVH
`define DBG_ACC_CONSTS_SVH

// Register offsets (register index on the debug link)
`define OFF_PHY_CONTROL_B        4'h3
`define OFF_ACCESS_KEY_STATUS    4'h7
`define OFF_SYSTEM_RESET_REQUEST 4'h8
`define OFF_LINK_CLOCK_SELECT    4'h9
`define OFF_SYSTEM_CONTROL       4'ha
`define OFF_SYSTEM_STATUS        4'hb
`define OFF_MEMORY_CHECK_STATE   4'hc

// phy_control_b fields
`define BIT_NEGACK_SUPPRESS      4
`define BIT_COLLISION_CHECK_OFF  3
`define BIT_PORT_DISABLE         2

// access_key_status fields
`define BIT_USER_ROW_KEY         5
`define BIT_PROGRAMMING_KEY      4
`define BIT_ERASE_KEY            3

// system_control fields
`define BIT_USER_ROW_DONE        1
`define BIT_SYSTEM_CLOCK_REQUEST 0

// system_status fields
`define BIT_SYSTEM_IN_RESET      5
`define BIT_SYSTEM_SLEEPING      4
`define BIT_PROG_READY           3
`define BIT_USER_ROW_PROG_READY  2
`define BIT_DEVICE_LOCKED        0

// Values
`define RESET_SIGNATURE          8'h59
`define CLKSEL_RESERVED          2'h0
`define CLKSEL_16MHZ             2'h1
`define CLKSEL_8MHZ              2'h2
`define CLKSEL_4MHZ              2'h3
`define CLKSEL_RESET             2'h3
`define MEMCHK_OFF               3'h0
`define MEMCHK_BUSY              3'h1
`define MEMCHK_PASS              3'h2
`define MEMCHK_FAIL              3'h4
`define BYTE_ZERO                8'h00

`endif

// ### dbg_acc_pkg.sv
package dbg_acc_pkg;
  typedef logic [3:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef enum logic [1:0] {
    CLK_RESERVED,
    CLK_16MHZ,
    CLK_8MHZ,
    CLK_4MHZ
  } debug_clock_t;
  typedef enum {
    KEY_IDLE,
    KEY_HELD
  } key_state_t;
endpackage

// ### key_if.sv
`timescale 1ns/1ps
`default_nettype none
interface key_if;
  logic key_found;
  logic seq_done;
  logic key_clear;
  logic key_active;
  modport holder (input key_found, input seq_done, input key_clear, output key_active);
  modport user   (output key_found, output seq_done, output key_clear, input key_active);
endinterface
`default_nettype wire

// ### key_holder.sv
`timescale 1ns/1ps
`default_nettype none
module key_holder (
  input  wire logic core_clk,
  input  wire logic reset,
  key_if.holder     kif
);
  import dbg_acc_pkg::*;

  key_state_t state_r;
  key_state_t state_nxt;

  // Set wins over clear so a key decoded in the clearing cycle is kept
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      KEY_IDLE: begin
        if (kif.key_found) begin
          state_nxt = KEY_HELD;
        end
      end
      KEY_HELD: begin
        if ((kif.seq_done || kif.key_clear) && !kif.key_found) begin
          state_nxt = KEY_IDLE;
        end
      end
      default: state_nxt = KEY_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= KEY_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign kif.key_active = (state_r == KEY_HELD);
endmodule
`default_nettype wire

// ### debug_access_control_regs.sv
`include "dbg_acc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module debug_access_control_regs (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  port_enable,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire dbg_acc_pkg::reg_addr_t reg_addr,
  input  wire dbg_acc_pkg::reg_data_t reg_wdata,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic                  user_row_key_found,
  input  wire logic                  programming_key_found,
  input  wire logic                  erase_key_found,
  input  wire logic                  programming_done,
  input  wire logic                  erase_done,
  input  wire logic                  system_reset_active,
  input  wire logic                  system_sleep,
  input  wire logic                  prog_ready,
  input  wire logic                  user_row_ready,
  input  wire logic                  lock_bits_set,
  input  wire logic [2:0]            memory_check_in,
  output logic                       negack_suppress,
  output logic                       collision_check_off,
  output logic                       phy_enabled,
  output logic                       system_reset_req,
  output logic                       system_clock_request,
  output logic                       user_row_start,
  output logic [1:0]                 debug_clock_select,
  output logic                       user_row_key_active,
  output logic                       programming_key_active,
  output logic                       erase_key_active
);
  import dbg_acc_pkg::*;

  key_if urow_kif ();
  key_if prog_kif ();
  key_if erase_kif ();

  logic       negack_r;
  logic       collision_r;
  logic       disabled_r;
  logic       phy_en_r;
  logic       rst_hold_r;
  logic [1:0] clksel_r;
  logic       system_clock_request_r;
  logic       urow_start_r;
  logic       sys_rst_seen_r;
  logic       port_enable_q_r;
  logic [7:0] rdata_r;
  logic       rvalid_r;
  logic [2:0] memchk_r;
  logic       locked_r;

  // Address decode, used both for writes and reads
  function automatic logic hit(input reg_addr_t a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  wire wr_phy_control_b  = reg_wr && hit(reg_addr, `OFF_PHY_CONTROL_B);
  wire wr_reset_request_code = reg_wr && hit(reg_addr, `OFF_SYSTEM_RESET_REQUEST);
  wire wr_clksel = reg_wr && hit(reg_addr, `OFF_LINK_CLOCK_SELECT);
  wire wr_sysctl = reg_wr && hit(reg_addr, `OFF_SYSTEM_CONTROL);
  wire rd_status = reg_rd && hit(reg_addr, `OFF_SYSTEM_STATUS);

  // Port disable acts like a local reset of port state
  wire disable_now  = wr_phy_control_b && reg_wdata[`BIT_PORT_DISABLE];
  wire port_reset   = reset || disable_now;
  wire enable_rise  = port_enable && !port_enable_q_r;
  // The requested system reset never feeds port_reset
  wire urow_key     = urow_kif.key_active;

  assign urow_kif.key_found  = user_row_key_found;
  assign urow_kif.seq_done   = 1'b0;
  assign urow_kif.key_clear  = port_reset;
  assign prog_kif.key_found  = programming_key_found;
  assign prog_kif.seq_done   = programming_done;
  assign prog_kif.key_clear  = port_reset;
  assign erase_kif.key_found = erase_key_found;
  assign erase_kif.seq_done  = erase_done;
  assign erase_kif.key_clear = port_reset;

  key_holder u_urow_key (
    .core_clk (core_clk),
    .reset    (reset),
    .kif      (urow_kif)
  );
  key_holder u_prog_key (
    .core_clk (core_clk),
    .reset    (reset),
    .kif      (prog_kif)
  );
  key_holder u_erase_key (
    .core_clk (core_clk),
    .reset    (reset),
    .kif      (erase_kif)
  );

  // Control register writes
  always_ff @(posedge core_clk) begin
    if (port_reset) begin
      negack_r    <= 1'b0;
      collision_r <= 1'b0;
      clksel_r    <= `CLKSEL_RESET;
    end else if (wr_phy_control_b) begin
      negack_r    <= reg_wdata[`BIT_NEGACK_SUPPRESS];
      collision_r <= reg_wdata[`BIT_COLLISION_CHECK_OFF];
    end else if (enable_rise) begin
      clksel_r <= `CLKSEL_RESET;
    end else if (wr_clksel) begin
      clksel_r <= reg_wdata[1:0];
    end
  end

  // Disable is sticky until the port is enabled again
  always_ff @(posedge core_clk) begin
    if (reset) begin
      disabled_r      <= 1'b0;
      phy_en_r        <= 1'b1;
      port_enable_q_r <= 1'b0;
    end else begin
      port_enable_q_r <= port_enable;
      if (disable_now) begin
        disabled_r <= 1'b1;
        phy_en_r   <= 1'b0;
      end else if (enable_rise) begin
        disabled_r <= 1'b0;
        phy_en_r   <= 1'b1;
      end
    end
  end

  // Reset request; port reset, port disable or a write of any value other than the signature clears it
  always_ff @(posedge core_clk) begin
    if (port_reset) begin
      rst_hold_r <= 1'b0;
    end else if (wr_reset_request_code) begin
      rst_hold_r <= (reg_wdata == `RESET_SIGNATURE);
    end
  end

  // System clock request
  always_ff @(posedge core_clk) begin
    if (port_reset) begin
      system_clock_request_r <= 1'b0;
    end else if (enable_rise) begin
      system_clock_request_r <= 1'b1;
    end else if (wr_sysctl) begin
      system_clock_request_r <= reg_wdata[`BIT_SYSTEM_CLOCK_REQUEST];
    end
  end

  // User-row done: a one-cycle start, gated by the decoded key
  always_ff @(posedge core_clk) begin
    if (port_reset) begin
      urow_start_r <= 1'b0;
    end else begin
      urow_start_r <= wr_sysctl && reg_wdata[`BIT_USER_ROW_DONE] && urow_key;
    end
  end

  // Reset status is sticky; a reset seen during the read cycle survives it
  wire sys_in_reset = system_reset_active || rst_hold_r;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sys_rst_seen_r <= 1'b0;
    end else if (sys_in_reset) begin
      sys_rst_seen_r <= 1'b1;
    end else if (rd_status) begin
      sys_rst_seen_r <= 1'b0;
    end
  end

  // Registered status sampling keeps outputs flop-driven
  always_ff @(posedge core_clk) begin
    if (reset) begin
      memchk_r <= `MEMCHK_OFF;
      locked_r <= 1'b1;
    end else begin
      memchk_r <= memory_check_in;
      locked_r <= lock_bits_set;
    end
  end

  logic [7:0] key_byte;
  logic [7:0] status_byte;
  logic [7:0] phy_control_b_byte;
  logic [7:0] rd_mux;
  always_comb begin
    key_byte = `BYTE_ZERO;
    key_byte[`BIT_USER_ROW_KEY]    = urow_key;
    key_byte[`BIT_PROGRAMMING_KEY] = prog_kif.key_active;
    key_byte[`BIT_ERASE_KEY]       = erase_kif.key_active;
    status_byte = `BYTE_ZERO;
    status_byte[`BIT_SYSTEM_IN_RESET]     = sys_rst_seen_r || sys_in_reset;
    status_byte[`BIT_SYSTEM_SLEEPING]     = system_sleep;
    status_byte[`BIT_PROG_READY]          = prog_ready;
    status_byte[`BIT_USER_ROW_PROG_READY] = user_row_ready;
    status_byte[`BIT_DEVICE_LOCKED]       = locked_r;
    phy_control_b_byte = `BYTE_ZERO;
    phy_control_b_byte[`BIT_NEGACK_SUPPRESS]     = negack_r;
    phy_control_b_byte[`BIT_COLLISION_CHECK_OFF] = collision_r;
    phy_control_b_byte[`BIT_PORT_DISABLE]        = disabled_r;
    case (reg_addr)
      `OFF_PHY_CONTROL_B:        rd_mux = phy_control_b_byte;
      `OFF_ACCESS_KEY_STATUS:    rd_mux = key_byte;
      `OFF_SYSTEM_RESET_REQUEST: rd_mux = {7'h00, rst_hold_r};
      `OFF_LINK_CLOCK_SELECT:    rd_mux = {6'h00, clksel_r};
      `OFF_SYSTEM_CONTROL:       rd_mux = {7'h00, system_clock_request_r};
      `OFF_SYSTEM_STATUS:        rd_mux = status_byte;
      `OFF_MEMORY_CHECK_STATE:   rd_mux = {5'h00, memchk_r};
      default:                   rd_mux = `BYTE_ZERO;
    endcase
  end

  // Read port exists only on the debug link side
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r  <= `BYTE_ZERO;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  logic ukey_q_r;
  logic pkey_q_r;
  logic ekey_q_r;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ukey_q_r <= 1'b0;
      pkey_q_r <= 1'b0;
      ekey_q_r <= 1'b0;
    end else begin
      ukey_q_r <= urow_key && !port_reset;
      pkey_q_r <= prog_kif.key_active && !port_reset;
      ekey_q_r <= erase_kif.key_active && !port_reset;
    end
  end

  assign reg_rdata              = rdata_r;
  assign reg_rvalid             = rvalid_r;
  assign negack_suppress        = negack_r;
  assign collision_check_off    = collision_r;
  assign phy_enabled            = phy_en_r;
  assign system_reset_req       = rst_hold_r;
  assign system_clock_request   = system_clock_request_r;
  assign user_row_start         = urow_start_r;
  assign debug_clock_select     = clksel_r;
  assign user_row_key_active    = ukey_q_r;
  assign programming_key_active = pkey_q_r;
  assign erase_key_active       = ekey_q_r;
endmodule
`default_nettype wire

// ### dbg_acc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dbg_acc_checker
  import dbg_acc_pkg::*;
(
  input wire logic      core_clk,
  input wire logic      reset,
  input wire logic      port_enable,
  input wire logic      reg_wr,
  input wire logic      reg_rd,
  input wire reg_addr_t reg_addr,
  input wire reg_data_t reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic      reg_rvalid,
  input wire logic      negack_suppress,
  input wire logic      collision_check_off,
  input wire logic      phy_enabled,
  input wire logic      system_reset_req,
  input wire logic      system_clock_request,
  input wire logic      user_row_start,
  input wire logic [1:0] debug_clock_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire wr_phy = reg_wr && reg_addr == 4'h3;
  wire wr_rst = reg_wr && reg_addr == 4'h8;
  wire wr_clk = reg_wr && reg_addr == 4'h9;
  wire wr_sys = reg_wr && reg_addr == 4'ha;
  wire row_wr = wr_sys && reg_wdata[1];
  property p_hold; wr_rst && reg_wdata == 8'h59 |=> system_reset_req; endproperty
  a_hold: assert property (p_hold) else $error("reset request not held");
  property p_release; wr_rst && reg_wdata != 8'h59 |=> !system_reset_req; endproperty
  a_release: assert property (p_release) else $error("reset request not released");
  property p_rstread;
    reg_rd && !reg_wr && reg_addr == 4'h8 |=> reg_rvalid && reg_rdata == {7'h00, $past(system_reset_req)};
  endproperty
  a_rstread: assert property (p_rstread) else $error("reset request readback wrong");
  property p_off; wr_phy && reg_wdata[2] |=> !phy_enabled && !system_clock_request && !system_reset_req; endproperty
  a_off: assert property (p_off) else $error("port disable incomplete");
  property p_offdef;
    wr_phy && reg_wdata[2] |=> !negack_suppress && !collision_check_off && debug_clock_select == 2'h3;
  endproperty
  a_offdef: assert property (p_offdef) else $error("port disable left settings");
  property p_nack; wr_phy && !reg_wdata[2] |=> negack_suppress == $past(reg_wdata[4]); endproperty
  a_nack: assert property (p_nack) else $error("negack suppress wrong");
  property p_coll; wr_phy && !reg_wdata[2] |=> collision_check_off == $past(reg_wdata[3]); endproperty
  a_coll: assert property (p_coll) else $error("collision check wrong");
  property p_sel; wr_clk && reg_wdata[1:0] != 2'h0 |=> debug_clock_select == $past(reg_wdata[1:0]); endproperty
  a_sel: assert property (p_sel) else $error("clock select wrong");
  property p_req;
    wr_sys && phy_enabled && !$rose(port_enable) |=> system_clock_request == $past(reg_wdata[0]);
  endproperty
  a_req: assert property (p_req) else $error("clock request wrong");
  property p_en; $rose(port_enable) && !reg_wr |=> system_clock_request && phy_enabled; endproperty
  a_en: assert property (p_en) else $error("enable did not request clock");
  property p_row; user_row_start |-> $past(row_wr); endproperty
  a_row: assert property (p_row) else $error("user row start without write");
endmodule
bind debug_access_control_regs dbg_acc_checker dbg_acc_checker_i (.core_clk(core_clk), .reset(reset),
  .port_enable(port_enable), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .negack_suppress(negack_suppress),
  .collision_check_off(collision_check_off), .phy_enabled(phy_enabled), .system_reset_req(system_reset_req),
  .system_clock_request(system_clock_request), .user_row_start(user_row_start),
  .debug_clock_select(debug_clock_select));
`default_nettype wire

// ### debug_host.sv
`timescale 1ns/1ps
`default_nettype none
module debug_host
  import dbg_acc_pkg::*;
(
  input  wire logic      core_clk,
  output logic           reg_wr,
  output logic           reg_rd,
  output reg_addr_t      reg_addr,
  output reg_data_t      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic      reg_rvalid
);
  // Brown-out at its top level here, so faster link clocks are allowed
  logic bod_top = 1'b1;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    if (a == 4'h9 && !bod_top) d[1:0] = 2'h3;
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input reg_addr_t a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
  // Row data must already sit in RAM before this
  task automatic finish_user_row; wr(4'ha, 8'h03); endtask
  task automatic finish_prog; wr(4'h8, 8'h59); endtask
endmodule
`default_nettype wire

// ### debug_access_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module debug_access_control_regs_test;
  import dbg_acc_pkg::*;
  typedef struct packed { reg_addr_t a; reg_data_t d; reg_data_t e; } row_t;
  logic core_clk, reset, port_enable, sys_rst, sleep, prog_rdy, urow_rdy, lock;
  logic [4:0] ev;
  logic [2:0] mchk;
  logic reg_wr, reg_rd, reg_rvalid, negack, coll, phy_en, rst_req, clk_req, urow_start;
  reg_addr_t reg_addr;
  reg_data_t reg_wdata;
  logic [7:0] reg_rdata, seen;
  logic [1:0] clk_sel;
  logic [2:0] keys;
  int mismatches = 0, comparisons = 0, starts = 0, n, i;
  row_t rows [10] = '{'{4'h8, 8'h59, 8'h01}, '{4'h8, 8'h12, 8'h00}, '{4'h9, 8'h01, 8'h01},
    '{4'h9, 8'h02, 8'h02}, '{4'h9, 8'h03, 8'h03}, '{4'ha, 8'h01, 8'h01}, '{4'ha, 8'h00, 8'h00},
    '{4'h3, 8'h18, 8'h18}, '{4'h7, 8'hff, 8'h00}, '{4'hd, 8'hff, 8'h00}};
  reg_addr_t ra [7] = '{4'h3, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  reg_data_t rv [7] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00};
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  debug_access_control_regs debug_access_control_regs_i (.core_clk(core_clk), .reset(reset),
    .port_enable(port_enable), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .user_row_key_found(ev[0]),
    .programming_key_found(ev[1]), .erase_key_found(ev[2]), .programming_done(ev[3]), .erase_done(ev[4]),
    .system_reset_active(sys_rst), .system_sleep(sleep), .prog_ready(prog_rdy), .user_row_ready(urow_rdy),
    .lock_bits_set(lock), .memory_check_in(mchk), .negack_suppress(negack), .collision_check_off(coll),
    .phy_enabled(phy_en), .system_reset_req(rst_req), .system_clock_request(clk_req),
    .user_row_start(urow_start), .debug_clock_select(clk_sel), .user_row_key_active(keys[0]),
    .programming_key_active(keys[1]), .erase_key_active(keys[2]));
  debug_host debug_host_i (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (urow_start === 1'b1) starts <= starts + 1;
  task automatic check(input string what, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic rchk(input reg_addr_t a, input reg_data_t e);
    debug_host_i.rd(a, seen);
    check($sformatf("register %h", a), seen, e);
  endtask
  task automatic pulse(input int b);
    @(posedge core_clk) ev[b] <= 1'b1;
    @(posedge core_clk) ev[b] <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    {reset, port_enable, ev, sys_rst, sleep, prog_rdy, urow_rdy, lock, mchk} = {1'b1, 10'h000, 1'b1, 3'h0};
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    for (i = 0; i < 7; i++) rchk(ra[i], rv[i]);
    @(posedge core_clk) port_enable <= 1'b1;
    rchk(4'ha, 8'h01);
    for (i = 0; i < 10; i++) begin
      debug_host_i.wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    n = starts;
    debug_host_i.wr(4'ha, 8'h02);
    repeat (2) @(posedge core_clk);
    check("start refused", 8'(starts - n), 8'h00);
    pulse(0);
    rchk(4'h7, 8'h20);
    debug_host_i.finish_user_row();
    repeat (2) @(posedge core_clk);
    check("start accepted", 8'(starts - n), 8'h01);
    pulse(1);
    pulse(2);
    rchk(4'h7, 8'h38);
    pulse(3);
    rchk(4'h7, 8'h28);
    pulse(4);
    rchk(4'h7, 8'h20);
    @(posedge core_clk) {sys_rst, sleep, prog_rdy, urow_rdy, lock} <= 5'h1e;
    repeat (3) @(posedge core_clk);
    debug_host_i.rd(4'hb, seen);
    rchk(4'hb, 8'h3c);
    @(posedge core_clk) sys_rst <= 1'b0;
    rchk(4'hb, 8'h3c);
    rchk(4'hb, 8'h1c);
    debug_host_i.wr(4'h9, 8'h01);
    debug_host_i.finish_prog();
    rchk(4'hb, 8'h3c);
    rchk(4'h9, 8'h01);
    debug_host_i.wr(4'h8, 8'h00);
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk) mchk <= codes[i];
      repeat (3) @(posedge core_clk);
      rchk(4'hc, {5'h00, codes[i]});
    end
    pulse(1);
    debug_host_i.wr(4'h3, 8'h1c);
    repeat (2) @(posedge core_clk);
    check("phy enabled", {7'h00, phy_en}, 8'h00);
    rchk(4'h3, 8'h04);
    rchk(4'h7, 8'h00);
    rchk(4'h9, 8'h03);
    rchk(4'ha, 8'h00);
    @(posedge core_clk) port_enable <= 1'b0;
    @(posedge core_clk) port_enable <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("phy enabled", {7'h00, phy_en}, 8'h01);
    rchk(4'ha, 8'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
